// [cwfc_config.sv]
// What this block does
// - Eight-bit count of time quanta per nominal bit, used for sampling.
// - Six-bit sample point, a binary fraction of the bit time below one.
// - Unused bits in timing and identifier registers ignore writes, read zero.
// - 29-bit wake identifier spans three full bytes plus bits 6..2 of last.
// - Standard identifiers sit in identifier bits 28 down to 18.
// - Bit 1 of lowest identifier register holds expected RTR value.
// - Bit 0 of lowest identifier register holds expected IDE value.
// - Compare-select one compares that identifier bit; zero ignores it.
// - First compare-select register covers identifier bits 28..21 in order.
// - Sample point loads 0x33 on reset and again on restart.
// - Identifier and compare-select registers clear on reset and again on restart.
// - Wake enabled only with valid flag; cleared on wake, reset, config change.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`include "cwfc_params.svh"

module cwfc_config #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 soft_reset,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output cwfc_pkg::cwfc_resp_t      s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output cwfc_pkg::cwfc_resp_t      s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Frame decoder side
  input  wire logic                 rx_frame_valid,
  input  wire logic [28:0]          rx_frame_id,
  input  wire logic                 rx_frame_ide,
  input  wire logic                 wake_event,
  // Configuration towards the bit sampler, then the match and wake outputs
  output logic [7:0]                bit_time_quanta,
  output logic [7:0]                sample_point_quanta,
  output logic [5:0]                sample_point_fraction,
  output logic                      selective_wake_enable,
  output logic                      expected_rtr,
  output logic                      id_match,
  output logic                      wake_up_frame
);
  import cwfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]  bit_time_q;
  logic [5:0]  sample_q;
  logic [7:0]  id_high_q;
  logic [7:0]  id_mid_q;
  logic [7:0]  id_low_q;
  logic [4:0]  id_tail_q;
  logic        rtr_q;
  logic        ide_q;
  logic [7:0]  cmp3_q;
  logic [7:0]  cmp2_q;
  logic [7:0]  cmp1_q;
  logic [4:0]  cmp0_q;
  logic        valid_q;
  logic        valid_d;

  // Bus handshake state
  logic              awready_q;
  logic              wready_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_byte_q;
  logic              w_lane_q;
  logic              bvalid_q;
  cwfc_resp_t        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  cwfc_resp_t        rresp_q;

  // Outputs towards the sampler and wake logic
  logic [7:0]  sample_quanta_q;
  logic        match_q;
  logic        wake_q;

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken independently

  wire aw_take  = s_axi_awvalid & awready_q;
  wire w_take   = s_axi_wvalid & wready_q;
  wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
  wire b_done   = bvalid_q & s_axi_bready;

  // Write decode, only the low byte lane reaches the 8-bit registers
  wire cwfc_idx_t wr_idx   = aw_addr_q[7:2];
  wire            wr_en    = wr_fire & w_lane_q;
  wire            wr_ctrl  = (wr_idx == `CWFC_IDX_CTRL);
  wire            wr_btl   = (wr_idx == `CWFC_IDX_BIT_TIME);
  wire            wr_frac  = (wr_idx == `CWFC_IDX_SAMPLE);
  wire            wr_id3   = (wr_idx == `CWFC_IDX_ID3);
  wire            wr_id2   = (wr_idx == `CWFC_IDX_ID2);
  wire            wr_id1   = (wr_idx == `CWFC_IDX_ID1);
  wire            wr_id0   = (wr_idx == `CWFC_IDX_ID0);
  wire            wr_cmp3  = (wr_idx == `CWFC_IDX_CMP3);
  wire            wr_cmp2  = (wr_idx == `CWFC_IDX_CMP2);
  wire            wr_cmp1  = (wr_idx == `CWFC_IDX_CMP1);
  wire            wr_cmp0  = (wr_idx == `CWFC_IDX_CMP0);
  wire            wr_cfg   = wr_btl | wr_frac | wr_id3 | wr_id2 | wr_id1 | wr_id0 |
                             wr_cmp3 | wr_cmp2 | wr_cmp1 | wr_cmp0;
  wire            wr_hit   = wr_ctrl | wr_cfg;
  wire            cfg_chg  = wr_en & wr_cfg;

  // Both resets load the same values; restart reloads every register that uses clr
  wire clr = ~aresetn | soft_reset;

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_take) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
    end
  end

  // Data capture; only the low byte matters to any register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (w_take) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      w_byte_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
    end
  end

  // Write response; unmapped words answer with an error and store nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= CWFC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? CWFC_RESP_OKAY : CWFC_RESP_SLVERR;
    end else if (b_done) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Bit timing; reserved top bits of the sample register are never stored
  always_ff @(posedge aclk) begin
    if (clr) begin
      bit_time_q <= `CWFC_RST_BIT_TIME;
      sample_q   <= 6'(`CWFC_RST_SAMPLE);
    end else begin
      if (wr_en & wr_btl)
        bit_time_q <= w_byte_q;
      if (wr_en & wr_frac)
        sample_q <= w_byte_q[`CWFC_FRAC_MSB:0];
    end
  end

  // Expected identifier and frame format bits
  always_ff @(posedge aclk) begin
    if (clr) begin
      id_high_q <= `CWFC_RST_ZERO;
      id_mid_q  <= `CWFC_RST_ZERO;
      id_low_q  <= `CWFC_RST_ZERO;
      id_tail_q <= 5'h00;
      rtr_q     <= 1'b0;
      ide_q     <= 1'b0;
    end else begin
      if (wr_en & wr_id3)
        id_high_q <= w_byte_q;
      if (wr_en & wr_id2)
        id_mid_q <= w_byte_q;
      if (wr_en & wr_id1)
        id_low_q <= w_byte_q;
      if (wr_en & wr_id0) begin
        id_tail_q <= w_byte_q[`CWFC_TAIL_MSB:`CWFC_TAIL_LSB];
        rtr_q     <= w_byte_q[`CWFC_RTR_BIT];
        ide_q     <= w_byte_q[`CWFC_IDE_BIT];
      end
    end
  end

  // Compare-select bytes, same bit order as the identifier bytes
  always_ff @(posedge aclk) begin
    if (clr) begin
      cmp3_q <= `CWFC_RST_ZERO;
      cmp2_q <= `CWFC_RST_ZERO;
      cmp1_q <= `CWFC_RST_ZERO;
      cmp0_q <= 5'h00;
    end else begin
      if (wr_en & wr_cmp3)
        cmp3_q <= w_byte_q;
      if (wr_en & wr_cmp2)
        cmp2_q <= w_byte_q;
      if (wr_en & wr_cmp1)
        cmp1_q <= w_byte_q;
      if (wr_en & wr_cmp0)
        cmp0_q <= w_byte_q[`CWFC_TAIL_MSB:`CWFC_TAIL_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration-valid flag
  // Hardware clears win over a host set in the same cycle: a stale
  // configuration must never be armed by a racing write.

  always_comb begin
    valid_d = valid_q;
    if (wr_en & wr_ctrl)
      valid_d = w_byte_q[`CWFC_VALID_BIT];
    if (cfg_chg | wake_event | wake_q)
      valid_d = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (clr)
      valid_q <= 1'b0;
    else
      valid_q <= valid_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel; one read in flight, answer the cycle after arrival

  wire            ar_take = s_axi_arvalid & arready_q;
  wire cwfc_idx_t rd_idx  = s_axi_araddr[7:2];

  // Read decode; reserved bits come back as zero
  wire        rd_ctrl = (rd_idx == `CWFC_IDX_CTRL);
  wire        rd_btl  = (rd_idx == `CWFC_IDX_BIT_TIME);
  wire        rd_frac = (rd_idx == `CWFC_IDX_SAMPLE);
  wire        rd_id3  = (rd_idx == `CWFC_IDX_ID3);
  wire        rd_id2  = (rd_idx == `CWFC_IDX_ID2);
  wire        rd_id1  = (rd_idx == `CWFC_IDX_ID1);
  wire        rd_id0  = (rd_idx == `CWFC_IDX_ID0);
  wire        rd_cmp3 = (rd_idx == `CWFC_IDX_CMP3);
  wire        rd_cmp2 = (rd_idx == `CWFC_IDX_CMP2);
  wire        rd_cmp1 = (rd_idx == `CWFC_IDX_CMP1);
  wire        rd_cmp0 = (rd_idx == `CWFC_IDX_CMP0);
  wire        rd_hit  = rd_ctrl | rd_btl | rd_frac | rd_id3 | rd_id2 | rd_id1 |
                        rd_id0 | rd_cmp3 | rd_cmp2 | rd_cmp1 | rd_cmp0;
  wire [7:0]  rd_byte = ({8{rd_ctrl}} & {7'h00, valid_q}) |
                        ({8{rd_btl}}  & bit_time_q) |
                        ({8{rd_frac}} & {2'b00, sample_q}) |
                        ({8{rd_id3}}  & id_high_q) |
                        ({8{rd_id2}}  & id_mid_q) |
                        ({8{rd_id1}}  & id_low_q) |
                        ({8{rd_id0}}  & {1'b0, id_tail_q, rtr_q, ide_q}) |
                        ({8{rd_cmp3}} & cmp3_q) |
                        ({8{rd_cmp2}} & cmp2_q) |
                        ({8{rd_cmp1}} & cmp1_q) |
                        ({8{rd_cmp0}} & {1'b0, cmp0_q, 2'b00});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= CWFC_RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= rd_hit ? CWFC_RESP_OKAY : CWFC_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identifier compare

  // Assembled identifier and compare-select vectors, bit 28 on top
  wire [28:0] cfg_id   = {id_high_q, id_mid_q, id_low_q, id_tail_q};
  wire [28:0] cfg_sel  = {cmp3_q, cmp2_q, cmp1_q, cmp0_q};
  // Standard frames carry only bits 28..18; the extension part is not compared
  wire [28:0] fmt_sel  = ide_q ? `CWFC_EXT_MASK : `CWFC_STD_MASK;
  wire [28:0] diff     = (rx_frame_id ^ cfg_id) & cfg_sel & fmt_sel;
  wire        id_hit   = (diff == 29'h0000_0000) & (rx_frame_ide == ide_q);

  // Match and wake pulses, one cycle after the decoder's strobe
  always_ff @(posedge aclk) begin
    if (clr) begin
      match_q <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      match_q <= rx_frame_valid & id_hit;
      wake_q  <= rx_frame_valid & id_hit & valid_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling point in quanta
  // The fraction times the bit length, truncated; a registered product
  // keeps the multiplier off the sampler's timing path.

  wire [13:0] frac_prod = 14'(bit_time_q) * 14'(sample_q);

  always_ff @(posedge aclk) begin
    if (clr)
      sample_quanta_q <= 8'h00;
    else
      sample_quanta_q <= frac_prod[13:6];
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign bit_time_quanta       = bit_time_q;
  assign sample_point_quanta   = sample_quanta_q;
  assign sample_point_fraction = sample_q;
  assign selective_wake_enable = valid_q;
  assign expected_rtr          = rtr_q;
  assign id_match              = match_q;
  assign wake_up_frame         = wake_q;

endmodule // cwfc_config

// [cwfc_config_asserts.sv]
`timescale 1ns/100ps
module cwfc_config_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        soft_reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        rx_frame_valid,
  input wire logic        wake_event,
  input wire logic [7:0]  bit_time_quanta,
  input wire logic [7:0]  sample_point_quanta,
  input wire logic [5:0]  sample_point_fraction,
  input wire logic        selective_wake_enable,
  input wire logic        id_match,
  input wire logic        wake_up_frame
);
  import cwfc_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Sample position follows both fields one cycle later; skip the cycle after a reset
  a_quanta_product: assert property ($past(aresetn) && !$past(soft_reset) |->
    sample_point_quanta == 8'((16'($past(bit_time_quanta)) * 16'($past(sample_point_fraction))) >> 6))
    else $error("sample point quanta wrong");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_soft_load: assert property (soft_reset |=> bit_time_quanta == 8'hA0 &&
    sample_point_fraction == 6'h33 && !selective_wake_enable) else $error("soft reset values wrong");
  a_match_strobe: assert property (id_match |-> $past(rx_frame_valid))
    else $error("match without frame");
  a_wake_match: assert property (wake_up_frame |-> id_match && $past(selective_wake_enable))
    else $error("wake without match or enable");
  a_wake_clears: assert property (wake_up_frame |=> !selective_wake_enable)
    else $error("enable kept after wake");
  a_event_clears: assert property (wake_event |=> !selective_wake_enable)
    else $error("enable kept after wake event");
  // Main scenarios reached
  c_wake: cover property (wake_up_frame);
  c_match_only: cover property (id_match && !wake_up_frame);
  c_soft: cover property (soft_reset);
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // cwfc_config_asserts

bind cwfc_config cwfc_config_asserts u_chk (.aclk, .aresetn, .soft_reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .rx_frame_valid, .wake_event, .bit_time_quanta, .sample_point_quanta, .sample_point_fraction,
  .selective_wake_enable, .id_match, .wake_up_frame);

// [cwfc_config_tb_top.sv]
`timescale 1ns/100ps
module cwfc_config_tb_top;
  import cwfc_pkg::*;
  logic        aclk, aresetn, soft_reset, wake_event, fvalid, fide, idm, wkf, en, rtr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, btq, spq, d;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [5:0]  spf;
  logic [28:0] fid, id;
  cwfc_resp_t  bresp, rresp;
  logic [7:0]  m [64];
  bit          mf;
  int          num_errors, n_checks, cyc;
  cwfc_config #(.ADDR_W(8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_frame_valid(fvalid), .rx_frame_id(fid), .rx_frame_ide(fide),
    .wake_event(wake_event), .bit_time_quanta(btq), .sample_point_quanta(spq),
    .sample_point_fraction(spf), .selective_wake_enable(en), .expected_rtr(rtr), .id_match(idm),
    .wake_up_frame(wkf)
  );
  cwfc_frame_src src (.aclk(aclk), .rx_frame_valid(fvalid), .rx_frame_id(fid), .rx_frame_ide(fide));
  ////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Readable bits of each index; unmapped reads zero
  function automatic logic [7:0] rmask(input logic [5:0] ix);
    case (ix)
      6'h20: return 8'h01;
      6'h22: return 8'h3F;
      6'h26: return 8'h7F;
      6'h2A: return 8'h7C;
      default: return (ix > 6'h20 && ix < 6'h2A) ? 8'hFF : 8'h00;
    endcase
  endfunction
  // Power-on contents of the model
  task automatic model_reset();
    foreach (m[i]) m[i] = 8'h00;
    m[6'h21] = 8'hA0;
    m[6'h22] = 8'h33;
    mf = 0;
  endtask
  // Write; address and data offered together, each released when taken
  task automatic wr(input logic [5:0] ix, input logic [7:0] v, input logic [3:0] st);
    bit a, w;
    a = 0;
    w = 0;
    awaddr <= {ix, 2'b00};
    wdata <= {24'($urandom), v};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      a = a | awready;
      w = w | wready;
      awvalid <= !a;
      wvalid <= !w;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, (ix inside {[6'h20:6'h2A]}) ? 2'b00 : 2'b10);
    if (ix inside {[6'h20:6'h2A]} && st[0]) begin
      m[ix] = v & rmask(ix);
      mf = (ix == 6'h20) & v[0];
    end
    @(posedge aclk);
  endtask
  // Read and compare against the model
  task automatic rd(input logic [5:0] ix);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    // Random stall so read data must stand while rready is low
    if ($urandom_range(1) == 1) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    check("rdata", rdata, (ix == 6'h20) ? 8'(mf) : m[ix] & rmask(ix));
    check("rresp", rresp, (ix inside {[6'h20:6'h2A]}) ? 2'b00 : 2'b10);
    @(posedge aclk);
  endtask
  // One frame from the far node, match worked out from the stored fields
  task automatic frame(input logic [28:0] fi, input logic fe);
    logic [28:0] cid, msk;
    bit hit;
    cid = {m[6'h23], m[6'h24], m[6'h25], m[6'h26][6:2]};
    msk = {m[6'h27], m[6'h28], m[6'h29], m[6'h2A][6:2]};
    if (!m[6'h26][0]) msk = msk & 29'h1FFC0000;
    hit = (((fi ^ cid) & msk) == 29'h0) && (fe == m[6'h26][0]);
    src.send(fi, fe);
    #1;
    check("id_match", idm, hit);
    check("wake_up_frame", wkf, hit && mf);
    if (hit) mf = 0;
    @(posedge aclk);
    #1;
    check("wake_enable", en, mf);
    @(posedge aclk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard, far above the run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {aresetn, soft_reset, wake_event, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    void'($urandom(32'hDF465A01));
    model_reset();
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 32; i <= 42; i++) rd(6'(i));
    $display("test reset_values done");
    repeat (2) for (int i = 33; i <= 42; i++) begin
      d = 8'($urandom);
      if (i == 38) d[1] = 1'b0;
      wr(6'(i), d, 4'hF);
      rd(6'(i));
    end
    wr(6'h21, 8'h5A, 4'hE);
    rd(6'h21);
    wr(6'h3F, 8'hFF, 4'hF);
    rd(6'h3F);
    check("bit_time", btq, m[6'h21]);
    check("fraction", spf, m[6'h22]);
    check("quanta", spq, (32'(m[6'h21]) * m[6'h22]) >> 6);
    check("rtr", rtr, m[6'h26][1]);
    $display("test register_access done");
    for (int k = 0; k < 36; k++) begin
      if (k % 6 == 0) begin
        wr(6'h20, 8'h01, 4'hF);
        wr(6'h26, 8'($urandom) & 8'hFD, 4'hF);
        rd(6'h20);
        wr(6'h27, 8'($urandom), 4'hF);
        wr(6'h20, 8'h01, 4'hF);
      end
      id = {m[6'h23], m[6'h24], m[6'h25], m[6'h26][6:2]};
      if (k % 4 == 1) id = id ^ (29'($urandom) & 29'h3FFFF);
      if (k % 4 == 3) id = id ^ 29'($urandom);
      frame(id, m[6'h26][0] ^ (k % 5 == 4));
    end
    $display("test frame_match done");
    wr(6'h20, 8'h01, 4'hF);
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    mf = 0;
    @(posedge aclk);
    rd(6'h20);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    model_reset();
    @(posedge aclk);
    for (int i = 32; i <= 42; i++) rd(6'(i));
    $display("test wake_and_soft_reset done");
    final_report();
  end
endmodule // cwfc_config_tb_top

// [cwfc_frame_src.sv]
`timescale 1ns/100ps
module cwfc_frame_src (
  input  wire logic        aclk,
  output logic             rx_frame_valid,
  output logic [28:0]      rx_frame_id,
  output logic             rx_frame_ide
);
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_id = 29'h0;
    rx_frame_ide = 1'b0;
  end
  ////////////////////////////////////////
  // One strobe per frame; lines inverted after so stale values never match by luck
  task automatic send(input logic [28:0] id, input logic ide);
    @(posedge aclk);
    rx_frame_valid <= 1'b1;
    rx_frame_id <= id;
    rx_frame_ide <= ide;
    @(posedge aclk);
    rx_frame_valid <= 1'b0;
    rx_frame_id <= ~id;
    rx_frame_ide <= ~ide;
  endtask
endmodule // cwfc_frame_src

// [cwfc_params.svh]
`ifndef CWFC_PARAMS_SVH
`define CWFC_PARAMS_SVH

// Register indexes; byte address is four times the index
`define CWFC_IDX_CTRL        6'h20
`define CWFC_IDX_BIT_TIME    6'h21
`define CWFC_IDX_SAMPLE      6'h22
`define CWFC_IDX_ID3         6'h23
`define CWFC_IDX_ID2         6'h24
`define CWFC_IDX_ID1         6'h25
`define CWFC_IDX_ID0         6'h26
`define CWFC_IDX_CMP3        6'h27
`define CWFC_IDX_CMP2        6'h28
`define CWFC_IDX_CMP1        6'h29
`define CWFC_IDX_CMP0        6'h2A

// Reset values
`define CWFC_RST_BIT_TIME    8'hA0
`define CWFC_RST_SAMPLE      8'h33
`define CWFC_RST_ZERO        8'h00

// Field positions
`define CWFC_FRAC_MSB        5
`define CWFC_TAIL_MSB        6
`define CWFC_TAIL_LSB        2
`define CWFC_RTR_BIT         1
`define CWFC_IDE_BIT         0
`define CWFC_VALID_BIT       0

// Identifier layout
`define CWFC_STD_MASK        29'h1FFC0000
`define CWFC_EXT_MASK        29'h1FFFFFFF

`endif

// [cwfc_pkg.sv]
package cwfc_pkg;

  // AXI response codes used by this slave
  typedef enum logic [1:0] {
    CWFC_RESP_OKAY   = 2'b00,
    CWFC_RESP_SLVERR = 2'b10
  } cwfc_resp_t;

  // Word index taken from a byte address
  typedef logic [5:0] cwfc_idx_t;

endpackage
